/* logic/uss_defines.svh */
`ifndef USS_DEFINES_SVH
`define USS_DEFINES_SVH

// register indices on the internal register port
`define USS_IDX_SCRATCH_C 2'h0
`define USS_IDX_SCRATCH_D 2'h1
`define USS_IDX_SYS_FLAGS 2'h2
`define USS_IDX_CONV_FLAGS 2'h3

`define USS_RST_SCRATCH_C 16'h0000
`define USS_RST_SCRATCH_D 16'h0000
`define USS_RST_SYS_FLAGS 16'h0000
`define USS_RST_CONV_FLAGS 16'h0000

// system flag positions
`define USS_POS_IO_SUPPLY_LOW 15
`define USS_POS_CONV_REF_LOW 14
`define USS_POS_FIVE_VOLT_LOW 13
`define USS_POS_ANALOG_FOUR_LOW 12
`define USS_POS_SYS_CLOCK_LOST 11
`define USS_POS_PLL_CLOCK_LOST 10
`define USS_POS_SYNC_LOST 9
`define USS_POS_DISCHARGE_FAILED 8
`define USS_POS_USB_OVERLOAD 7
`define USS_POS_STARTUP_FAILED 4
`define USS_POS_CONVERSION_DONE 3
`define USS_POS_STARTUP_DONE 2

// implemented system flag bits; 6-5 and 1-0 are absent
`define USS_SYS_IMPL_MASK 16'hFF9C

`endif

/* logic/uss_pkg.sv */
package uss_pkg;
	typedef logic [15:0] uss_word_t;
	typedef logic [1:0] uss_idx_t;
	typedef enum logic [2:0] {
		USS_IDLE = 3'b001,
		USS_WRITE = 3'b010,
		USS_READ = 3'b100
	} uss_acc_e;
endpackage : uss_pkg

/* logic/uss_flag_if.sv */
`timescale 1ns/1ps
interface uss_flag_if #(parameter int WIDTH = 16);
	logic [WIDTH-1:0] set_ev;
	logic [WIDTH-1:0] clr_wr;
	logic [WIDTH-1:0] flags;
	modport owner (input set_ev, input clr_wr, output flags);
	modport user (output set_ev, output clr_wr, input flags);
endinterface : uss_flag_if

/* logic/uss_flag_bank.sv */
`timescale 1ns/1ps
module uss_flag_bank #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] IMPL_MASK = '1
) (
	input wire logic clk_sys,
	input wire logic rst,
	uss_flag_if.owner fl
);
	logic [WIDTH-1:0] flags_ff;
	logic [WIDTH-1:0] nxt_flags;

	// set wins over a clear in the same cycle so no event is lost
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		if (IMPL_MASK[i]) begin : g_impl
			assign nxt_flags[i] = fl.set_ev[i] | (flags_ff[i] & ~fl.clr_wr[i]);
		end else begin : g_none
			assign nxt_flags[i] = 1'b0;
		end
	end

	// one process owns the whole vector, so every bit has a single driver
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	assign fl.flags = flags_ff;
endmodule : uss_flag_bank

/* logic/uss_regs.sv */
`timescale 1ns/1ps
`include "uss_defines.svh"
// Contract
// - scratch C, two bytes, read/write, zero reset
// - scratch C never saved, zero after power-on
// - scratch D 16-bit read/write, zero default
// - scratch D not kept across power cycle
// - hardware sets flags, writing one clears; bit 3 follows conversion_complete and ignores the write
// - bits 15-12 latch four supply undervoltages
// - bit 11 system clock, 10 PLL lost
// - bit 9 sets on sync loss
// - bit 8 sets on discharge failure
// - bit 7 sets on USB overload
// - bits 6-5, 1-0 always read zero
// - bit 4 sets on startup failure
// - bit 3 zero converting, one when done
// - bit 2 sets when startup completes
// - converter flag register, write one clears
module uss_regs (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire uss_pkg::uss_idx_t reg_idx,
	input wire uss_pkg::uss_word_t reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic io_supply_low,
	input wire logic converter_reference_low,
	input wire logic five_volt_supply_low,
	input wire logic analog_four_volt_supply_low,
	input wire logic system_clock_lost,
	input wire logic pll_clock_lost,
	input wire logic sync_lost,
	input wire logic output_discharge_failed,
	input wire logic usb_overload_flag,
	input wire logic startup_failed,
	input wire logic conversion_complete,
	input wire logic startup_complete,
	input wire logic [15:0] converter_events,
	output logic [15:0] user_scratch_c,
	output logic [15:0] user_scratch_d,
	output logic [15:0] system_event_flags,
	output logic [15:0] converter_event_flags
);
	uss_pkg::uss_word_t scratch_c_ff;
	uss_pkg::uss_word_t scratch_d_ff;
	uss_pkg::uss_word_t rdata_ff;
	logic rvalid_ff;
	uss_pkg::uss_acc_e acc_ff;
	uss_pkg::uss_acc_e nxt_acc;
	logic [15:0] sys_set;
	logic [15:0] sys_clr;
	logic [15:0] conv_clr;
	logic wr_sys;
	logic wr_conv;

	uss_flag_if #(.WIDTH(16)) sys_if ();
	uss_flag_if #(.WIDTH(16)) conv_if ();

	// access tracker: a read answers one cycle after it is taken, write wins if both
	always_comb begin
		if (reg_wr) begin
			nxt_acc = uss_pkg::USS_WRITE;
		end else if (reg_rd) begin
			nxt_acc = uss_pkg::USS_READ;
		end else begin
			nxt_acc = uss_pkg::USS_IDLE;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			acc_ff <= uss_pkg::USS_IDLE;
		end else begin
			acc_ff <= nxt_acc;
		end
	end

	// scratch registers live only in flops with no path to storage
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scratch_c_ff <= `USS_RST_SCRATCH_C;
		end else if (reg_wr && reg_idx == `USS_IDX_SCRATCH_C) begin
			scratch_c_ff[15:8] <= reg_wdata[15:8];
			scratch_c_ff[7:0] <= reg_wdata[7:0];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scratch_d_ff <= `USS_RST_SCRATCH_D;
		end else if (reg_wr && reg_idx == `USS_IDX_SCRATCH_D) begin
			scratch_d_ff <= reg_wdata;
		end
	end

	assign wr_sys = reg_wr && (reg_idx == `USS_IDX_SYS_FLAGS);
	assign wr_conv = reg_wr && (reg_idx == `USS_IDX_CONV_FLAGS);
	// zeros in the write data clear nothing
	assign sys_clr = wr_sys ? reg_wdata : 16'h0000;
	assign conv_clr = wr_conv ? reg_wdata : 16'h0000;

	always_comb begin
		sys_set = 16'h0000;
		sys_set[`USS_POS_IO_SUPPLY_LOW] = io_supply_low;
		sys_set[`USS_POS_CONV_REF_LOW] = converter_reference_low;
		sys_set[`USS_POS_FIVE_VOLT_LOW] = five_volt_supply_low;
		sys_set[`USS_POS_ANALOG_FOUR_LOW] = analog_four_volt_supply_low;
		sys_set[`USS_POS_SYS_CLOCK_LOST] = system_clock_lost;
		sys_set[`USS_POS_PLL_CLOCK_LOST] = pll_clock_lost;
		sys_set[`USS_POS_SYNC_LOST] = sync_lost;
		sys_set[`USS_POS_DISCHARGE_FAILED] = output_discharge_failed;
		sys_set[`USS_POS_USB_OVERLOAD] = usb_overload_flag;
		sys_set[`USS_POS_STARTUP_FAILED] = startup_failed;
		sys_set[`USS_POS_STARTUP_DONE] = startup_complete;
	end

	assign sys_if.set_ev = sys_set;
	assign sys_if.clr_wr = sys_clr & ~(16'h0001 << `USS_POS_CONVERSION_DONE);
	assign conv_if.set_ev = converter_events;
	assign conv_if.clr_wr = conv_clr;

	uss_flag_bank #(.WIDTH(16), .IMPL_MASK(`USS_SYS_IMPL_MASK)) u_sys (
		.clk_sys(clk_sys),
		.rst(rst),
		.fl(sys_if.owner)
	);

	uss_flag_bank #(.WIDTH(16), .IMPL_MASK(16'hFFFF)) u_conv (
		.clk_sys(clk_sys),
		.rst(rst),
		.fl(conv_if.owner)
	);

	// conversion status follows the converter live rather than latching
	always_comb begin
		system_event_flags = sys_if.flags;
		system_event_flags[`USS_POS_CONVERSION_DONE] = conversion_complete;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_ff <= 16'h0000;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= (nxt_acc == uss_pkg::USS_READ);
			if (nxt_acc == uss_pkg::USS_READ) begin
				case (reg_idx)
					`USS_IDX_SCRATCH_C: rdata_ff <= scratch_c_ff;
					`USS_IDX_SCRATCH_D: rdata_ff <= scratch_d_ff;
					`USS_IDX_SYS_FLAGS: rdata_ff <= system_event_flags;
					`USS_IDX_CONV_FLAGS: rdata_ff <= conv_if.flags;
					default: rdata_ff <= 16'h0000;
				endcase
			end
		end
	end

	assign reg_rdata = rdata_ff;
	assign reg_rvalid = rvalid_ff && (acc_ff == uss_pkg::USS_READ);
	assign user_scratch_c = scratch_c_ff;
	assign user_scratch_d = scratch_d_ff;
	assign converter_event_flags = conv_if.flags;
endmodule : uss_regs

/* test/uss_regs_asserts.sv */
`timescale 1ns/1ps
module uss_regs_asserts (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire uss_pkg::uss_idx_t reg_idx,
	input wire uss_pkg::uss_word_t reg_wdata,
	input wire logic reg_rvalid,
	input wire logic sync_lost,
	input wire logic conversion_complete,
	input wire logic [15:0] converter_events,
	input wire logic [15:0] user_scratch_c,
	input wire logic [15:0] user_scratch_d,
	input wire logic [15:0] system_event_flags,
	input wire logic [15:0] converter_event_flags
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire logic wr_sys = reg_wr && reg_idx == 2'h2;
	a_read_answered: assert property (reg_rd && !reg_wr |=> reg_rvalid)
		else $error("read not answered");
	a_scratch_c_wr: assert property (reg_wr && reg_idx == 2'h0 |=>
		user_scratch_c == $past(reg_wdata)) else $error("scratch c write lost");
	a_scratch_d_wr: assert property (reg_wr && reg_idx == 2'h1 |=>
		user_scratch_d == $past(reg_wdata)) else $error("scratch d write lost");
	a_unimpl_zero: assert property ((system_event_flags & 16'h0063) == 16'h0000)
		else $error("absent flag bit set");
	a_sync_sets: assert property (sync_lost |=> system_event_flags[9])
		else $error("sync flag not set");
	a_flag_sticky: assert property (system_event_flags[15] && !(wr_sys && reg_wdata[15])
		|=> system_event_flags[15]) else $error("flag dropped");
	a_flag_clears: assert property (wr_sys && reg_wdata[9] && !sync_lost
		|=> !system_event_flags[9]) else $error("flag not cleared");
	a_done_live: assert property (system_event_flags[3] == conversion_complete)
		else $error("done bit not live");
	a_conv_clears: assert property (reg_wr && reg_idx == 2'h3 && reg_wdata[0]
		&& !converter_events[0] |=> !converter_event_flags[0]) else $error("conv flag kept");
	c_read: cover property (reg_rvalid);
	c_sync: cover property (sync_lost ##1 system_event_flags[9]);
	c_clear: cover property (wr_sys && reg_wdata[9] ##1 !system_event_flags[9]);
endmodule : uss_regs_asserts
bind uss_regs uss_regs_asserts uss_regs_asserts_i (.clk_sys, .rst, .reg_wr, .reg_rd,
	.reg_idx, .reg_wdata, .reg_rvalid, .sync_lost, .conversion_complete, .converter_events,
	.user_scratch_c, .user_scratch_d, .system_event_flags, .converter_event_flags);

/* test/uss_host.sv */
`timescale 1ns/1ps
module uss_host (
	input wire logic clk_sys,
	input wire logic [15:0] reg_rdata,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0,
	output uss_pkg::uss_idx_t reg_idx = 2'h0,
	output uss_pkg::uss_word_t reg_wdata = 16'h0000
);
	task automatic wr(input uss_pkg::uss_idx_t i, input uss_pkg::uss_word_t d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_idx <= i;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		// stale data would hide a design that latches without the strobe
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input uss_pkg::uss_idx_t i, output uss_pkg::uss_word_t q);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_idx <= i;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		q = reg_rdata;
	endtask : rd
endmodule : uss_host

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [11:0] ev = '0;
	logic [15:0] cev = '0;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] rdata;
	uss_pkg::uss_idx_t reg_idx;
	uss_pkg::uss_word_t reg_wdata, q, r, m;
	int err_total = 0;
	int n_checks = 0;
	localparam int POS [12] = '{15, 14, 13, 12, 11, 10, 9, 8, 7, 4, 3, 2};
	always #5 clk_sys = ~clk_sys;
	uss_host uss_host_i (.clk_sys, .reg_rdata(rdata), .reg_wr, .reg_rd, .reg_idx, .reg_wdata);
	uss_regs uss_regs_i (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_idx, .reg_wdata,
		.reg_rdata(rdata), .reg_rvalid(), .io_supply_low(ev[0]), .converter_reference_low(ev[1]),
		.five_volt_supply_low(ev[2]), .analog_four_volt_supply_low(ev[3]),
		.system_clock_lost(ev[4]), .pll_clock_lost(ev[5]), .sync_lost(ev[6]),
		.output_discharge_failed(ev[7]), .usb_overload_flag(ev[8]), .startup_failed(ev[9]),
		.conversion_complete(ev[10]), .startup_complete(ev[11]), .converter_events(cev),
		.user_scratch_c(), .user_scratch_d(), .system_event_flags(), .converter_event_flags());
	function automatic uss_pkg::uss_word_t bit_of(input int k);
		return 16'h0001 << POS[k];
	endfunction : bit_of
	task automatic chk(input string s, input uss_pkg::uss_word_t seen, uss_pkg::uss_word_t e);
		n_checks++;
		if (seen !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h seen %h", s, e, seen);
		end
	endtask : chk
	task automatic rc(input uss_pkg::uss_idx_t i, input uss_pkg::uss_word_t e);
		uss_host_i.rd(i, q);
		chk($sformatf("reg%0d", i), q, e);
	endtask : rc
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	initial begin
		#100000;
		err_total++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h60D3));
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) rc(2'(i), 16'h0000);
		$display("done reset");
		for (int i = 0; i < 8; i++) begin
			r = (i < 2) ? 16'hFFFF : 16'($urandom);
			uss_host_i.wr({1'b0, i[0]}, r);
			rc({1'b0, i[0]}, r);
		end
		$display("done scratch");
		for (int k = 0; k < 12; k++) begin
			if (k == 10) continue;
			@(posedge clk_sys);
			ev[k] <= 1'b1;
			@(posedge clk_sys);
			ev[k] <= 1'b0;
			// ones everywhere else also hit the absent bits
			uss_host_i.wr(2'h2, ~bit_of(k));
			rc(2'h2, bit_of(k));
			uss_host_i.wr(2'h2, bit_of(k));
			rc(2'h2, 16'h0000);
		end
		$display("done flags");
		@(posedge clk_sys);
		ev[10] <= 1'b1;
		uss_host_i.wr(2'h2, 16'h0008);
		rc(2'h2, 16'h0008);
		@(posedge clk_sys);
		ev[10] <= 1'b0;
		rc(2'h2, 16'h0000);
		r = 16'($urandom);
		m = 16'($urandom);
		@(posedge clk_sys);
		cev <= r;
		@(posedge clk_sys);
		cev <= 16'h0000;
		uss_host_i.wr(2'h3, m);
		rc(2'h3, r & ~m);
		$display("done live and converter");
		uss_host_i.wr(2'h0, 16'hA5C3);
		uss_host_i.wr(2'h1, 16'h3C5A);
		@(posedge clk_sys);
		rst <= 1'b1;
		@(posedge clk_sys);
		rst <= 1'b0;
		rc(2'h0, 16'h0000);
		rc(2'h1, 16'h0000);
		$display("done second reset");
		report_and_stop();
	end
endmodule : testbench
